// *** src/usc_map.vh ***
`ifndef USC_MAP_VH
`define USC_MAP_VH
// Register offsets
`define USC_OFS_STATUS   3'h0
`define USC_OFS_CLKSRC   3'h1
`define USC_OFS_COMMAND  3'h2
`define USC_OFS_MODE     3'h3
`define USC_OFS_DATA     3'h4
// Status bit positions
`define USC_ST_BRK       7
`define USC_ST_FE        6
`define USC_ST_PE        5
`define USC_ST_OE        4
`define USC_ST_TXEMP     3
`define USC_ST_TX_READY     2
`define USC_ST_FIFO_FULL     1
`define USC_ST_RX_READY     0
// Command fields and codes
`define USC_CMD_MISC     6:4
`define USC_CMD_TXC      3:2
`define USC_CMD_RXC      1:0
`define USC_MISC_RST_RX  3'h2
`define USC_MISC_RST_TX  3'h3
`define USC_MISC_RST_ERR 3'h4
`define USC_EN_CODE      2'h1
`define USC_DIS_CODE     2'h2
// Mode register one fields
`define USC_MODE_PM      4:3
`define USC_MODE_PT      2
`define USC_MODE_LEN     1:0
`define USC_PM_NONE      2'h2
`define USC_PM_FORCE     2'h1
`define USC_PM_MULTI     2'h3
// Clock select
`define USC_CS_RX        7:4
`define USC_CS_TX        3:0
`define USC_CS_PRESCALE  4'hD
`define USC_CS_EXT16     4'hE
`define USC_CS_EXT       4'hF
`define USC_CLKSRC_RST   8'hDD
`define USC_MODE_RST     8'h13
// Timing in selected clock-source ticks, and FIFO depth
`define USC_OVS_LAST     4'hF
`define USC_MID_START    4'h7
`define USC_FIFO_DEPTH   2'h3
`endif

// *** src/usc_top.v ***
// Contract
// - Break sets flag, takes one FIFO entry
// - After break, wait two high ticks
// - Stop sampled mid-bit; low sets framing
// - Per-character flags shown for FIFO head
// - Parity flag: error, or multidrop A/D
// - Overrun when full and one waiting
// - Overrun sticks until error reset command
// - Tx empty after last stop, idle
// - Tx ready on hand-off or enable
// - Loads while tx disabled are dropped
// - Three-deep FIFO, full flag, excess lost
// - Rx ready while FIFO holds characters
// - Receiver clock select in bits 7-4
// - Transmitter clock select in bits 3-0
// - Rx and tx sources independent
// - Clock select resets to 0xDD
// - Error reset clears four error flags
// - Receiver reset empties FIFO, disables
`timescale 1ns/1ns
`include "usc_map.vh"
module usc_top (
    // Clock and reset
    input  wire       clk_i,
    input  wire       sys_rst_i,
    // Register port
    input  wire [2:0] addr_i,
    input  wire [7:0] wr_data_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output wire [7:0] rd_data_o,
    // Serial side
    input  wire       serial_rx_line_i,
    input  wire       ext_timer_clock_in_i,
    output wire       serial_tx_o
);
    // ========================================
    // Clock source selection
    // ========================================
    function sel_tick;
        input [3:0] code;
        input       pre;
        input       ext;
        input       ext16;
        begin
            case (code)
                `USC_CS_EXT16: sel_tick = ext16;
                `USC_CS_EXT:   sel_tick = ext;
                // Reserved codes fall back to the prescaler
                default:       sel_tick = pre;
            endcase
        end
    endfunction

    reg  [7:0] clksrc_reg;
    reg  [7:0] mode_reg;
    reg        pre_reg;
    reg        ext_prev_reg;
    reg  [3:0] ext_div_reg;
    wire       ext_tick   = ext_timer_clock_in_i & ~ext_prev_reg;
    wire       ext16_tick = ext_tick & (ext_div_reg == `USC_OVS_LAST);
    wire rx_tick = sel_tick(clksrc_reg[`USC_CS_RX], pre_reg, ext_tick, ext16_tick);
    wire tx_tick = sel_tick(clksrc_reg[`USC_CS_TX], pre_reg, ext_tick, ext16_tick);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pre_reg      <= 1'b0;
            // Starts high so a pin already high at release is no edge
            ext_prev_reg <= 1'b1;
            ext_div_reg  <= 4'h0;
        end else begin
            pre_reg      <= ~pre_reg;
            ext_prev_reg <= ext_timer_clock_in_i;
            if (ext_tick)
                ext_div_reg <= ext_div_reg + 4'h1;
        end
    end

    // ========================================
    // Register decode
    // ========================================
    wire       wr_cmd  = wr_i & (addr_i == `USC_OFS_COMMAND);
    wire [2:0] misc    = wr_data_i[`USC_CMD_MISC];
    wire       rst_rx  = wr_cmd & (misc == `USC_MISC_RST_RX);
    wire       rst_tx  = wr_cmd & (misc == `USC_MISC_RST_TX);
    wire       rst_err = wr_cmd & (misc == `USC_MISC_RST_ERR);
    wire       rx_on   = wr_cmd & (wr_data_i[`USC_CMD_RXC] == `USC_EN_CODE);
    wire       rx_off  = wr_cmd & (wr_data_i[`USC_CMD_RXC] == `USC_DIS_CODE);
    wire       tx_on   = wr_cmd & (wr_data_i[`USC_CMD_TXC] == `USC_EN_CODE);
    wire       tx_off  = wr_cmd & (wr_data_i[`USC_CMD_TXC] == `USC_DIS_CODE);
    wire       rd_data = rd_i & (addr_i == `USC_OFS_DATA);
    wire       wr_hold = wr_i & (addr_i == `USC_OFS_DATA);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            clksrc_reg <= `USC_CLKSRC_RST;
            mode_reg   <= `USC_MODE_RST;
        end else if (wr_i) begin
            if (addr_i == `USC_OFS_CLKSRC)
                clksrc_reg <= wr_data_i;
            if (addr_i == `USC_OFS_MODE)
                mode_reg <= wr_data_i;
        end
    end

    // ========================================
    // Receiver
    // ========================================
    localparam [5:0] RX_IDLE = 6'h01;
    localparam [5:0] RX_STRT = 6'h02;
    localparam [5:0] RX_DATA = 6'h04;
    localparam [5:0] RX_PAR  = 6'h08;
    localparam [5:0] RX_STOP = 6'h10;
    localparam [5:0] RX_BRKW = 6'h20;

    reg  [5:0] rx_st_reg;
    reg        rx_en_reg;
    reg  [3:0] rx_cnt_reg;
    reg  [2:0] rx_bit_reg;
    reg  [7:0] rx_sh_reg;
    reg        rx_par_reg;
    reg        brk_hi_reg;
    wire [1:0] pm   = mode_reg[`USC_MODE_PM];
    wire [2:0] last = {1'b1, mode_reg[`USC_MODE_LEN]};
    wire       line = serial_rx_line_i;
    wire       mid  = rx_tick & (rx_cnt_reg == `USC_OVS_LAST);

    // all-zero character with no stop bit
    wire c_brk = (rx_sh_reg == 8'h00) & ~rx_par_reg & ~line;
    // stop bit checked at its middle
    wire c_fe  = ~line;
    reg  c_pe;
    always @* begin
        case (pm)
            `USC_PM_MULTI: c_pe = rx_par_reg;
            `USC_PM_FORCE: c_pe = rx_par_reg ^ mode_reg[`USC_MODE_PT];
            `USC_PM_NONE:  c_pe = 1'b0;
            default:       c_pe = (^rx_sh_reg) ^ rx_par_reg ^ mode_reg[`USC_MODE_PT];
        endcase
    end
    wire        done = (rx_st_reg == RX_STOP) & mid;
    wire [10:0] c_word = {c_brk, c_fe, c_pe & ~c_brk, rx_sh_reg};

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_st_reg  <= RX_IDLE;
            rx_en_reg  <= 1'b0;
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg  <= 8'h00;
            rx_par_reg <= 1'b0;
            brk_hi_reg <= 1'b0;
        end else if (rst_rx | rx_off) begin
            rx_st_reg <= RX_IDLE;
            rx_en_reg <= 1'b0;
        end else begin
            if (rx_on)
                rx_en_reg <= 1'b1;
            if (rx_tick)
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            case (rx_st_reg)
                RX_IDLE: begin
                    rx_cnt_reg <= 4'h0;
                    if (rx_en_reg & ~line) begin
                        rx_st_reg  <= RX_STRT;
                        rx_sh_reg  <= 8'h00;
                        rx_par_reg <= 1'b0;
                        rx_bit_reg <= 3'h0;
                    end
                end
                RX_STRT: begin
                    if (rx_tick & (rx_cnt_reg == `USC_MID_START)) begin
                        rx_cnt_reg <= 4'h0;
                        rx_st_reg  <= line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (mid) begin
                        rx_sh_reg[rx_bit_reg] <= line;
                        rx_bit_reg            <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == last)
                            rx_st_reg <= (pm == `USC_PM_NONE) ? RX_STOP : RX_PAR;
                    end
                end
                RX_PAR: begin
                    if (mid) begin
                        rx_par_reg <= line;
                        rx_st_reg  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (mid) begin
                        brk_hi_reg <= 1'b0;
                        rx_st_reg  <= c_brk ? RX_BRKW : RX_IDLE;
                    end
                end
                RX_BRKW: begin
                    // line high on two successive ticks
                    if (rx_tick) begin
                        brk_hi_reg <= line;
                        if (line & brk_hi_reg)
                            rx_st_reg <= RX_IDLE;
                    end
                end
                default: rx_st_reg <= RX_IDLE;
            endcase
        end
    end

    // ========================================
    // Receive FIFO and waiting character
    // ========================================
    reg  [10:0] fifo_mem [0:2];
    reg  [1:0]  fifo_cnt_reg;
    reg  [10:0] wait_reg;
    reg         wait_vld_reg;
    reg         oe_reg;
    wire        full = (fifo_cnt_reg == `USC_FIFO_DEPTH);
    wire        pop  = rd_data & (fifo_cnt_reg != 2'h0);
    integer     i;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            fifo_cnt_reg <= 2'h0;
            wait_vld_reg <= 1'b0;
            wait_reg     <= 11'h000;
            oe_reg       <= 1'b0;
            for (i = 0; i < 3; i = i + 1)
                fifo_mem[i] <= 11'h000;
        end else if (rst_rx) begin
            // empties FIFO, clears full and ready
            fifo_cnt_reg <= 2'h0;
            wait_vld_reg <= 1'b0;
        end else begin
            if (pop) begin
                fifo_mem[0] <= fifo_mem[1];
                fifo_mem[1] <= fifo_mem[2];
            end
            if (pop & wait_vld_reg) begin
                fifo_mem[fifo_cnt_reg - 2'h1] <= wait_reg;
                wait_vld_reg                  <= 1'b0;
            end else if (pop) begin
                fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
            end
            // error reset clears stored flags
            // Placed before the push so a character completing now keeps its flags
            if (rst_err) begin
                oe_reg         <= 1'b0;
                wait_reg[10:8] <= 3'h0;
                for (i = 0; i < 3; i = i + 1)
                    fifo_mem[i][10:8] <= 3'h0;
            end
            if (done) begin
                if (~full | pop) begin
                    if (pop & ~wait_vld_reg) begin
                        // Pop and push together leave the count as it was
                        fifo_mem[fifo_cnt_reg - 2'h1] <= c_word;
                        fifo_cnt_reg                  <= fifo_cnt_reg;
                    end else if (~pop) begin
                        fifo_mem[fifo_cnt_reg] <= c_word;
                        fifo_cnt_reg           <= fifo_cnt_reg + 2'h1;
                    end
                    if (pop & wait_vld_reg) begin
                        wait_reg     <= c_word;
                        wait_vld_reg <= 1'b1;
                    end
                end else begin
                    wait_reg     <= c_word;
                    wait_vld_reg <= 1'b1;
                    if (wait_vld_reg)
                        oe_reg <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // Transmitter
    // ========================================
    reg        tx_en_reg;
    reg  [7:0] hold_reg;
    reg        hold_vld_reg;
    reg  [9:0] tx_sh_reg;
    reg  [3:0] tx_left_reg;
    reg  [3:0] tx_cnt_reg;
    reg        tx_ready_reg;
    reg        txemp_reg;
    reg        tx_line_reg;
    wire       tx_busy = (tx_left_reg != 4'h0);
    wire       load    = tx_en_reg & hold_vld_reg & ~tx_busy;
    wire       bit_end = tx_busy & tx_tick & (tx_cnt_reg == `USC_OVS_LAST);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_en_reg    <= 1'b0;
            hold_reg     <= 8'h00;
            hold_vld_reg <= 1'b0;
            tx_sh_reg    <= 10'h3FF;
            tx_left_reg  <= 4'h0;
            tx_cnt_reg   <= 4'h0;
            tx_ready_reg    <= 1'b0;
            txemp_reg    <= 1'b0;
            tx_line_reg  <= 1'b1;
        end else if (rst_tx | tx_off) begin
            // disabled reads not empty, not ready
            tx_en_reg    <= 1'b0;
            hold_vld_reg <= 1'b0;
            tx_left_reg  <= 4'h0;
            tx_ready_reg    <= 1'b0;
            txemp_reg    <= 1'b0;
            tx_line_reg  <= 1'b1;
        end else begin
            if (tx_on & ~tx_en_reg) begin
                tx_en_reg <= 1'b1;
                tx_ready_reg <= 1'b1;
            end
            if (wr_hold & tx_en_reg) begin
                hold_reg     <= wr_data_i;
                hold_vld_reg <= 1'b1;
                tx_ready_reg    <= 1'b0;
                txemp_reg    <= 1'b0;
            end else if (load) begin
                hold_vld_reg <= 1'b0;
                tx_ready_reg    <= 1'b1;
            end
            if (load) begin
                tx_sh_reg   <= {1'b1, hold_reg, 1'b0} | ~(10'h3FF >> (3'h4 - last[1:0]));
                tx_left_reg <= {1'b0, last} + 4'h3;
                tx_cnt_reg  <= 4'h0;
                txemp_reg   <= 1'b0;
            end else if (tx_busy) begin
                if (tx_tick)
                    tx_cnt_reg <= tx_cnt_reg + 4'h1;
                tx_line_reg <= tx_sh_reg[0];
                if (bit_end) begin
                    tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
                    tx_left_reg <= tx_left_reg - 4'h1;
                    if ((tx_left_reg == 4'h1) & ~hold_vld_reg & ~wr_hold)
                        txemp_reg <= 1'b1;
                end
            end else begin
                tx_line_reg <= 1'b1;
            end
        end
    end

    // ========================================
    // Read data
    // ========================================
    reg  [7:0] rd_data_reg;
    // head entry flags, ready while not empty
    wire [7:0] status = {fifo_mem[0][10:8], oe_reg, txemp_reg, tx_ready_reg, full, fifo_cnt_reg != 2'h0};

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_reg <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `USC_OFS_STATUS:  rd_data_reg <= status;
                `USC_OFS_CLKSRC:  rd_data_reg <= clksrc_reg;
                `USC_OFS_MODE:    rd_data_reg <= mode_reg;
                `USC_OFS_DATA:    rd_data_reg <= fifo_mem[0][7:0];
                default:          rd_data_reg <= 8'h00;
            endcase
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    assign rd_data_o   = rd_data_reg;
    assign serial_tx_o = tx_line_reg;
endmodule // usc_top

// *** verif/usc_chk.sv ***
`timescale 1ns/1ns
// ==========================================
// Port checker
module usc_chk (
    // Clock, reset and register port
    input wire       clk_i,
    input wire       sys_rst_i,
    input wire [2:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] rd_data_o,
    // Serial side
    input wire       serial_rx_line_i,
    input wire       ext_timer_clock_in_i,
    input wire       serial_tx_o
);
    logic [7:0] cs_reg;
    logic       oe_reg;
    logic       off_reg;
    logic       srd_reg;
    wire        srd = rd_i && addr_i == 3'h0;
    wire        cmd = wr_i && addr_i == 3'h2;
    // Shadows of what software should see; the transmitter starts disabled
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cs_reg  <= 8'hDD;
            oe_reg  <= 1'b0;
            off_reg <= 1'b1;
            srd_reg <= 1'b0;
        end else begin
            srd_reg <= srd;
            if (wr_i && addr_i == 3'h1)
                cs_reg <= wr_data_i;
            if (cmd && wr_data_i[6:4] == 3'h4)
                oe_reg <= 1'b0;
            else if (srd_reg && rd_data_o[4])
                oe_reg <= 1'b1;
            if (cmd && wr_data_i[3:2] == 2'h1)
                off_reg <= 1'b0;
            else if (cmd && (wr_data_i[3:2] == 2'h2 || wr_data_i[6:4] == 3'h3))
                off_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_cs; rd_i && addr_i == 3'h1 |=> rd_data_o == cs_reg; endproperty
    a_cs: assert property (p_cs) else $error("clock source readback");
    property p_oe; srd_reg && oe_reg |-> rd_data_o[4]; endproperty
    a_oe: assert property (p_oe) else $error("overrun flag lost");
    property p_clr; cmd && wr_data_i[6:4] == 3'h4 ##[1:4] srd |=> rd_data_o[7:4] == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("error flags not cleared");
    property p_rrx; cmd && wr_data_i[6:4] == 3'h2 ##[1:4] srd |=> rd_data_o[1:0] == 2'h0; endproperty
    a_rrx: assert property (p_rrx) else $error("receiver reset");
    property p_dis; cmd && wr_data_i[3:2] == 2'h2 ##[1:4] srd |=> rd_data_o[3:2] == 2'h0; endproperty
    a_dis: assert property (p_dis) else $error("tx flags after disable");
    property p_quiet; off_reg [*3] |-> serial_tx_o; endproperty
    a_quiet: assert property (p_quiet) else $error("line active while disabled");
    property p_emp; srd_reg && rd_data_o[3] |-> serial_tx_o; endproperty
    a_emp: assert property (p_emp) else $error("empty while line low");
    property p_full; srd_reg && rd_data_o[1] |-> rd_data_o[0]; endproperty
    a_full: assert property (p_full) else $error("full without ready");
    c_oe: cover property (srd_reg && rd_data_o[4]);
    c_brk: cover property (srd_reg && rd_data_o[7]);
    c_full: cover property (srd_reg && rd_data_o[1]);
endmodule // usc_chk

bind usc_top usc_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .serial_rx_line_i(serial_rx_line_i),
    .ext_timer_clock_in_i(ext_timer_clock_in_i), .serial_tx_o(serial_tx_o));

// *** verif/usc_peer.sv ***
`timescale 1ns/1ns
// ==========================================
// Remote serial device
module usc_peer (
    // Clock and serial side
    input  wire        clk_i,
    input  wire        serial_tx_o,
    output logic       serial_rx_line_i,
    output logic       ext_timer_clock_in_i
);
    int         bit_cyc = 32;
    logic [1:0] ph = 2'h0;
    initial serial_rx_line_i = 1'b1;
    initial ext_timer_clock_in_i = 1'b0;
    // Timer input runs free: one rising edge every 8 cycles
    always @(posedge clk_i) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3)
            ext_timer_clock_in_i <= ~ext_timer_clock_in_i;
    end
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int hold);
        serial_rx_line_i <= 1'b0;
        repeat (bit_cyc) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            serial_rx_line_i <= d[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        serial_rx_line_i <= stp;
        repeat (bit_cyc * hold) @(posedge clk_i);
        serial_rx_line_i <= 1'b1;
        repeat (bit_cyc * 2) @(posedge clk_i);
    endtask
    // Transmitter runs from the bus clock: 32 cycles a bit
    task automatic recv(output logic [7:0] d, output bit ok);
        int n;
        n = 0;
        while (serial_tx_o === 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        ok = n < 3000;
        repeat (16) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (32) @(posedge clk_i);
            d[i] = serial_tx_o;
        end
        repeat (32) @(posedge clk_i);
        ok = ok && serial_tx_o === 1'b1;
    endtask
endmodule // usc_peer

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    wire  [7:0] rd_data_o;
    wire        serial_rx_line_i;
    wire        ext_timer_clock_in_i;
    wire        serial_tx_o;
    int         num_errors = 0;
    int         cmp_count = 0;
    logic [7:0] g;
    logic [7:0] v;
    logic [7:0] b [5];
    logic [7:0] tab [6];
    logic       p;
    bit         ok;
    always #4 clk_i = ~clk_i;
    usc_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
        .rd_i(rd_i), .rd_data_o(rd_data_o), .serial_rx_line_i(serial_rx_line_i),
        .ext_timer_clock_in_i(ext_timer_clock_in_i), .serial_tx_o(serial_tx_o));
    usc_peer u_peer (.clk_i(clk_i), .serial_tx_o(serial_tx_o), .serial_rx_line_i(serial_rx_line_i),
        .ext_timer_clock_in_i(ext_timer_clock_in_i));
    // ==========================================
    // Bus tasks and checks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic chk(input logic [7:0] x, input logic [7:0] e, input string m);
        cmp_count++;
        if (x !== e) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, x, e);
        end
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e, input string s);
        rd(3'h0, g);
        chk(g & m, e, s);
    endtask
    // Parity flag: address bit in multidrop, else mismatch against odd, even or forced bit
    function automatic logic pe_exp(input logic [7:0] md, input logic [7:0] d, input logic pb);
        if (md[4:3] == 2'h3)
            return pb;
        return pb ^ (md[3] ? md[2] : (^d ^ md[2]));
    endfunction
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(26286));
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(3'h1, g);
        chk(g, 8'hDD, "clock source reset");
        st(8'hFF, 8'h00, "status reset");
        tab = '{8'hDE, 8'hEF, 8'hFD, 8'($urandom), 8'($urandom), 8'hDD};
        foreach (tab[i]) begin
            wr(3'h1, tab[i]);
            rd(3'h1, g);
            chk(g, tab[i], "clock source");
        end
        $display("test clock select done");
        wr(3'h2, 8'h01);
        for (int i = 0; i < 5; i++) begin
            b[i] = 8'($urandom);
            u_peer.send({1'b0, b[i]}, 8, 1'b1, 1);
            if (i == 2)
                st(8'h13, 8'h03, "full");
        end
        st(8'h13, 8'h13, "overrun");
        for (int i = 0; i < 4; i++) begin
            rd(3'h4, g);
            chk(g, b[i == 3 ? 4 : i], "fifo order");
        end
        st(8'h13, 8'h10, "drained");
        wr(3'h2, 8'h40);
        st(8'hF0, 8'h00, "error clear");
        $display("test overrun done");
        u_peer.send(9'h000, 8, 1'b0, 4);
        st(8'h81, 8'h81, "break");
        rd(3'h4, g);
        chk(g, 8'h00, "break data");
        st(8'h01, 8'h00, "one entry");
        wr(3'h2, 8'h40);
        u_peer.send({1'b0, 8'($urandom) | 8'h01}, 8, 1'b0, 1);
        st(8'h41, 8'h41, "framing");
        wr(3'h2, 8'h20);
        st(8'h03, 8'h00, "receiver reset");
        wr(3'h2, 8'h41);
        $display("test break and framing done");
        tab = '{8'h07, 8'h03, 8'h0B, 8'h0F, 8'h1B, 8'h1B};
        foreach (tab[i]) begin
            wr(3'h3, tab[i]);
            b[0] = 8'($urandom);
            p = 1'($urandom);
            u_peer.send({p, b[0]}, 9, 1'b1, 1);
            st(8'h21, {2'h0, pe_exp(tab[i], b[0], p), 5'h01}, "parity");
            rd(3'h4, v);
            chk(v, b[0], "parity data");
            wr(3'h2, 8'h40);
        end
        wr(3'h3, 8'h13);
        $display("test parity done");
        wr(3'h1, 8'hFD);
        u_peer.bit_cyc = 128;
        u_peer.send({1'b0, b[3]}, 8, 1'b1, 1);
        rd(3'h4, g);
        chk(g, b[3], "timer clocked rx");
        // Timer divided by 16: one tick per 128 cycles, 2048 cycles a bit
        wr(3'h1, 8'hED);
        u_peer.bit_cyc = 2048;
        u_peer.send({1'b0, b[0]}, 8, 1'b1, 1);
        rd(3'h4, g);
        chk(g, b[0], "divided timer rx");
        // Reserved receiver code keeps the prescaled clock
        wr(3'h1, 8'h3D);
        u_peer.bit_cyc = 32;
        u_peer.send({1'b0, b[4]}, 8, 1'b1, 1);
        rd(3'h4, g);
        chk(g, b[4], "reserved code rx");
        wr(3'h2, 8'h02);
        u_peer.send({1'b0, b[2]}, 8, 1'b1, 1);
        st(8'h03, 8'h00, "receiver disabled");
        wr(3'h2, 8'h04);
        st(8'h0C, 8'h04, "tx enable");
        fork
            u_peer.recv(v, ok);
            wr(3'h4, b[1]);
        join
        chk(v, b[1], "tx data");
        chk({7'h0, ok}, 8'h01, "tx frame");
        repeat (32) @(posedge clk_i);
        st(8'h0C, 8'h0C, "tx idle");
        wr(3'h2, 8'h08);
        st(8'h0C, 8'h00, "tx disable");
        wr(3'h4, b[2]);
        wr(3'h2, 8'h04);
        u_peer.recv(v, ok);
        chk({7'h0, ok}, 8'h00, "dropped load");
        wr(3'h2, 8'h30);
        st(8'h0C, 8'h00, "tx reset");
        $display("test transmit done");
        summarize();
    end
endmodule // tb_top
